// *** rtl/ttc_top.sv ***
// Summary of operation
// - three 16-bit timers, falling-edge counters too
// - timer ticks once per 12 or 6 clocks
// - count pin sampled per machine cycle
// - gate bit adds ext pin high condition
// - count select: 0 timer, 1 counter
// - modes 13, 16, 8 reload, split/stop
// - overflow flags set by hw, cleared by ack/sw
// - ext irq flag, edge or level trigger
// - clock out toggles on timer2 overflow
// - down count enable allows timer2 down
// - timer2 overflow flag not set in baud mode
// - timer2 ext flag on qualified timer2_ext_pin edge
// - baud sources select timer2 or timer1 pulse
// - timer2_ext_pin edges need enable and no baud use
// - timer2 run and count select
// - capture or reload; baud forces reload
// - 8-bit reload keeps high byte
// - split high byte uses timer1 run and flag
// - up/down follows timer2_ext_pin; fixed down reload
// - clock out 50% duty, no interrupt
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ttc_consts.svh"
module ttc_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire ttc_pkg::ttc_pins_t pins_i,
   input wire logic half_cycle_mode_i,
   output logic clock_out_pin_o,
   output logic tx_baud_tick_o,
   output logic rx_baud_tick_o,
   output logic timer0_irq_o,
   output logic timer1_irq_o,
   output logic timer2_irq_o,
   output logic ext0_irq_o,
   output logic ext1_irq_o
);
   import ttc_pkg::*;
   logic [5:0] sync1, sync2, samp;
   logic [3:0] mc_cnt;
   logic mc_tick;
   logic [7:0] mode, ctrl, timer2_output_direction, timer2_run_and_flags;
   logic [7:0] tl0, th0, tl1, th1, tl2, th2, capl, caph;
   logic wr, rd_pend;
   logic [3:0] a;
   logic [7:0] wd;
   ttc_pins_t ps, pp;
   // pin synchroniser, second stage only read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= 6'h3F;
         sync2 <= 6'h3F;
      end else begin
         sync1 <= pins_i;
         sync2 <= sync1;
      end
   end
   assign ps = sync2;
   // machine cycle divider
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mc_cnt <= 4'h0;
      end else if (mc_tick) begin
         mc_cnt <= 4'h0;
      end else begin
         mc_cnt <= mc_cnt + 4'h1;
      end
   end
   assign mc_tick = (mc_cnt == (half_cycle_mode_i ? `TTC_MC_12T
                                 : `TTC_MC_6T));
   // once per machine cycle sample of pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         samp <= 6'h3F;
      end else if (mc_tick) begin
         samp <= sync2;
      end
   end
   assign pp = samp;
   // wishbone classic single-cycle slave
   assign wr = cyc_i & stb_i & we_i & sel_i[0] & ~ack_o;
   assign a = adr_i;
   assign wd = dat_i[7:0];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i & stb_i & ~ack_o;
      end
   end
   function automatic logic fall(input logic prev, input logic now);
      fall = prev & ~now;
   endfunction : fall
   // tick enables
   logic cs0, cs1, g0, g1, en0, en1, ev0, ev1, split, en0h;
   logic [1:0] m0, m1;
   assign m0 = mode[1:0];
   assign m1 = mode[5:4];
   assign cs0 = mode[2];
   assign cs1 = mode[6];
   assign g0 = mode[3];
   assign g1 = mode[7];
   assign split = (m0 == 2'b11);
   assign ev0 = mc_tick & (cs0 ? fall(pp.t0, ps.t0) : 1'b1);
   assign ev1 = mc_tick & (cs1 ? fall(pp.t1, ps.t1) : 1'b1);
   assign en0 = ctrl[4] & (~g0 | ps.int0_n);
   assign en1 = ctrl[6] & (~g1 | ps.int1_n);
   assign en0h = mc_tick & ctrl[6];
   // generic 8051 style counter step
   logic [15:0] n0, n1;
   logic o0, o1, o0h;
   function automatic logic [16:0] step(input logic [1:0] m,
         input logic [7:0] lo, input logic [7:0] hi);
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0] c8;
      c13 = {hi, lo[4:0]} + 14'h1;
      c16 = {1'b0, hi, lo} + 17'h1;
      c8 = {1'b0, lo} + 9'h1;
      step = 17'h0;
      unique case (m)
         2'b00: step = {c13[13], c13[12:5], 3'b000, c13[4:0]};
         2'b01: step = c16;
         2'b10: step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
         2'b11: step = {c8[8], hi, c8[7:0]};
      endcase
   endfunction : step
   logic [16:0] s0, s1;
   logic [8:0] h0;
   assign s0 = step(m0, tl0, th0);
   assign s1 = step(m1, tl1, th1);
   assign h0 = {1'b0, th0} + 9'h1;
   assign o0 = en0 & ev0 & s0[16];
   assign o1 = en1 & ev1 & s1[16] & (m1 != 2'b11);
   assign o0h = split & en0h & h0[8];
   // timer2
   logic t2run, t2cs, baud, cprl, exen, down_count_enable, timer2_clock_out_en, ext_ev, ev2, up;
   logic [16:0] c2u;
   logic [15:0] c2d, t2v;
   logic o2;
   assign t2run = timer2_run_and_flags[2];
   assign t2cs = timer2_run_and_flags[1];
   assign cprl = timer2_run_and_flags[0];
   assign exen = timer2_run_and_flags[3];
   assign baud = timer2_run_and_flags[5] | timer2_run_and_flags[4];
   assign down_count_enable = timer2_output_direction[0];
   assign timer2_clock_out_en = timer2_output_direction[1];
   assign t2v = {th2, tl2};
   assign ev2 = t2run & mc_tick &
                (t2cs ? fall(pp.t2, ps.t2) : 1'b1);
   assign ext_ev = exen & ~baud & mc_tick & fall(pp.timer2_ext_pin, ps.timer2_ext_pin);
   assign up = ~(down_count_enable & ~cprl & ~baud) | ps.timer2_ext_pin;
   assign c2u = {1'b0, t2v} + 17'h1;
   assign c2d = t2v - 16'h1;
   assign o2 = ev2 & (up ? c2u[16] : (t2v == {caph, capl}));
   // registers and counters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode <= `TTC_RST_BYTE;
         timer2_output_direction <= `TTC_RST_BYTE;
      end else if (wr & a == `TTC_ADR_MODE) begin
         mode <= wd;
      end else if (wr & a == `TTC_ADR_TIMER2_OUTPUT_DIRECTION) begin
         timer2_output_direction <= {6'h00, wd[1:0]};
      end
   end
   // ctrl: ovf1 run1 ovf0 run0 ext1 type1 ext0 type0
   logic e0_set, e1_set;
   logic [1:0] int_d;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_d <= 2'b11;
      end else begin
         int_d <= {ps.int1_n, ps.int0_n};
      end
   end
   assign e0_set = ctrl[0] ? fall(int_d[0], ps.int0_n) : ~ps.int0_n;
   assign e1_set = ctrl[2] ? fall(int_d[1], ps.int1_n) : ~ps.int1_n;
   logic ack0, ack1, acke0, acke1, wctl;
   assign wctl = wr & a == `TTC_ADR_CTRL;
   assign ack0 = wr & a == `TTC_ADR_ACK & wd[0];
   assign ack1 = wr & a == `TTC_ADR_ACK & wd[1];
   assign acke0 = wr & a == `TTC_ADR_ACK & wd[2];
   assign acke1 = wr & a == `TTC_ADR_ACK & wd[3];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `TTC_RST_BYTE;
      end else begin
         ctrl[6] <= wctl ? wd[6] : ctrl[6];
         ctrl[4] <= wctl ? wd[4] : ctrl[4];
         ctrl[2] <= wctl ? wd[2] : ctrl[2];
         ctrl[0] <= wctl ? wd[0] : ctrl[0];
         ctrl[7] <= (o1 | o0h) |
                    (ctrl[7] & ~ack1 & ~(wctl & ~wd[7]));
         ctrl[5] <= o0 | (ctrl[5] & ~ack0 & ~(wctl & ~wd[5]));
         ctrl[3] <= e1_set | (ctrl[3] & ~acke1 & ~(wctl & ~wd[3]));
         ctrl[1] <= e0_set | (ctrl[1] & ~acke0 & ~(wctl & ~wd[1]));
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tl0 <= `TTC_RST_BYTE;
         th0 <= `TTC_RST_BYTE;
      end else if (wr & a == `TTC_ADR_TL0) begin
         tl0 <= wd;
      end else if (wr & a == `TTC_ADR_TH0) begin
         th0 <= wd;
      end else begin
         if (en0 & ev0) begin
            tl0 <= s0[7:0];
            if (!split) begin
               th0 <= s0[15:8];
            end
         end
         if (split & en0h) begin
            th0 <= h0[7:0];
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tl1 <= `TTC_RST_BYTE;
         th1 <= `TTC_RST_BYTE;
      end else if (wr & a == `TTC_ADR_TL1) begin
         tl1 <= wd;
      end else if (wr & a == `TTC_ADR_TH1) begin
         th1 <= wd;
      end else if (en1 & ev1 & m1 != 2'b11) begin
         {th1, tl1} <= s1[15:0];
      end
   end
   // timer2_run_and_flags: ovf ext rxsrc txsrc exen run cs cprl
   logic t2ovf_set, t2ext_set, wt2;
   assign wt2 = wr & a == `TTC_ADR_TIMER2_RUN_AND_FLAGS;
   assign t2ovf_set = o2 & ~baud & ~(timer2_clock_out_en & ~t2cs);
   assign t2ext_set = ext_ev | (o2 & down_count_enable & ~cprl & ~baud);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer2_run_and_flags <= `TTC_RST_BYTE;
      end else begin
         timer2_run_and_flags[5:0] <= wt2 ? wd[5:0] : timer2_run_and_flags[5:0];
         timer2_run_and_flags[7] <= t2ovf_set | (timer2_run_and_flags[7] & ~(wt2 & ~wd[7]));
         if (o2 & down_count_enable & ~cprl & ~baud) begin
            timer2_run_and_flags[6] <= ~timer2_run_and_flags[6];
         end else begin
            timer2_run_and_flags[6] <= t2ext_set | (timer2_run_and_flags[6] & ~(wt2 & ~wd[6]));
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tl2 <= `TTC_RST_BYTE;
         th2 <= `TTC_RST_BYTE;
      end else if (wr & a == `TTC_ADR_TL2) begin
         tl2 <= wd;
      end else if (wr & a == `TTC_ADR_TH2) begin
         th2 <= wd;
      end else if (o2) begin
         if (up | cprl & ~baud) begin
            {th2, tl2} <= (cprl & ~baud) ? 16'h0000
                          : {caph, capl};
         end else begin
            {th2, tl2} <= `TTC_T2_DOWN_LOAD;
         end
      end else if (ext_ev & ~cprl & ~down_count_enable) begin
         {th2, tl2} <= {caph, capl};
      end else if (ev2) begin
         {th2, tl2} <= up ? c2u[15:0] : c2d;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capl <= `TTC_RST_BYTE;
         caph <= `TTC_RST_BYTE;
      end else if (wr & a == `TTC_ADR_CAPL) begin
         capl <= wd;
      end else if (wr & a == `TTC_ADR_CAPH) begin
         caph <= wd;
      end else if (ext_ev & cprl) begin
         {caph, capl} <= t2v;
      end
   end
   // clock out and baud pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_out_pin_o <= 1'b0;
         tx_baud_tick_o <= 1'b0;
         rx_baud_tick_o <= 1'b0;
      end else begin
         if (o2 & timer2_clock_out_en & ~t2cs) begin
            clock_out_pin_o <= ~clock_out_pin_o;
         end
         tx_baud_tick_o <= timer2_run_and_flags[4] ? o2 : (o1 | o0h);
         rx_baud_tick_o <= timer2_run_and_flags[5] ? o2 : (o1 | o0h);
      end
   end
   // read mux and interrupt lines
   logic [7:0] rd;
   always_comb begin
      rd = 8'h00;
      unique case (a)
         `TTC_ADR_MODE: rd = mode;
         `TTC_ADR_CTRL: rd = ctrl;
         `TTC_ADR_TL0: rd = tl0;
         `TTC_ADR_TH0: rd = th0;
         `TTC_ADR_TL1: rd = tl1;
         `TTC_ADR_TH1: rd = th1;
         `TTC_ADR_TIMER2_OUTPUT_DIRECTION: rd = timer2_output_direction;
         `TTC_ADR_TIMER2_RUN_AND_FLAGS: rd = timer2_run_and_flags;
         `TTC_ADR_TL2: rd = tl2;
         `TTC_ADR_TH2: rd = th2;
         `TTC_ADR_CAPL: rd = capl;
         `TTC_ADR_CAPH: rd = caph;
         default: rd = 8'h00;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
         timer0_irq_o <= 1'b0;
         timer1_irq_o <= 1'b0;
         timer2_irq_o <= 1'b0;
         ext0_irq_o <= 1'b0;
         ext1_irq_o <= 1'b0;
      end else begin
         dat_o <= {24'h000000, rd};
         timer0_irq_o <= ctrl[5];
         timer1_irq_o <= ctrl[7];
         ext0_irq_o <= ctrl[1];
         ext1_irq_o <= ctrl[3];
         timer2_irq_o <= timer2_run_and_flags[7] |
                         (timer2_run_and_flags[6] & ~(down_count_enable & ~cprl & ~baud));
      end
   end
endmodule : ttc_top

// *** rtl/ttc_consts.svh ***
`ifndef TTC_CONSTS_SVH
`define TTC_CONSTS_SVH
`define TTC_ADR_MODE 4'h0
`define TTC_ADR_CTRL 4'h1
`define TTC_ADR_TL0 4'h2
`define TTC_ADR_TH0 4'h3
`define TTC_ADR_TL1 4'h4
`define TTC_ADR_TH1 4'h5
`define TTC_ADR_TIMER2_OUTPUT_DIRECTION 4'h6
`define TTC_ADR_TIMER2_RUN_AND_FLAGS 4'h7
`define TTC_ADR_TL2 4'h8
`define TTC_ADR_TH2 4'h9
`define TTC_ADR_CAPL 4'hA
`define TTC_ADR_CAPH 4'hB
`define TTC_ADR_ACK 4'hC
`define TTC_RST_BYTE 8'h00
`define TTC_MC_12T 4'hB
`define TTC_MC_6T 4'h5
`define TTC_T2_DOWN_LOAD 16'hFFFF
`endif

// *** rtl/ttc_pkg.sv ***
package ttc_pkg;
   typedef struct packed {
      logic [3:0] adr;
      logic we;
      logic [7:0] dat;
      logic stb;
   } ttc_req_t;
   typedef struct packed {
      logic t0;
      logic t1;
      logic t2;
      logic int0_n;
      logic int1_n;
      logic timer2_ext_pin;
   } ttc_pins_t;
endpackage : ttc_pkg

// *** verif/ttc_properties.sv ***
`timescale 1ns/1ps
module ttc_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic tx_baud_tick_o,
   input wire logic rx_baud_tick_o,
   input wire logic timer0_irq_o,
   input wire logic timer1_irq_o,
   input wire logic timer2_irq_o
);
   logic wr_req;
   assign wr_req = cyc_i & stb_i & we_i;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_answer;
      ack_o ##1 !ack_o;
   endsequence
   a_ack_answer: assert property (
      s_take |=> s_answer) else $error("ack not one pulse after request");
   a_ack_cause: assert property (
      ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
   a_read_unmapped: assert property (
      ack_o && !we_i && adr_i > 4'hC |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_tx_spacing: assert property (
      tx_baud_tick_o |=> !tx_baud_tick_o [*5]) else $error("tx tick spacing");
   a_rx_spacing: assert property (
      rx_baud_tick_o |=> !rx_baud_tick_o [*5]) else $error("rx tick spacing");
   a_tf0_clear: assert property (
      $fell(timer0_irq_o) |-> $past(wr_req)) else $error("tf0 cleared alone");
   a_tf1_clear: assert property (
      $fell(timer1_irq_o) |-> $past(wr_req)) else $error("tf1 cleared alone");
   a_tf2_clear: assert property (
      $fell(timer2_irq_o) |-> $past(wr_req)) else $error("tf2 cleared alone");
endmodule : ttc_props
bind ttc_top ttc_props u_props (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .dat_o(dat_o), .ack_o(ack_o), .tx_baud_tick_o(tx_baud_tick_o),
   .rx_baud_tick_o(rx_baud_tick_o), .timer0_irq_o(timer0_irq_o),
   .timer1_irq_o(timer1_irq_o), .timer2_irq_o(timer2_irq_o));

// *** verif/ttc_pin_model.sv ***
`timescale 1ns/1ps
module ttc_pin_model #(parameter int HOLD = 30) (
   input wire logic clk_i,
   output ttc_pkg::ttc_pins_t pins_o
);
   import ttc_pkg::*;
   logic [5:0] lvl = 6'h3F;
   assign pins_o = lvl;
   // each level held over several machine cycles
   task automatic pulse(input int b, input int n);
      for (int i = 0; i < n; i++) begin
         repeat (HOLD) @(posedge clk_i);
         lvl[b] <= 1'b0;
         repeat (HOLD) @(posedge clk_i);
         lvl[b] <= 1'b1;
      end
      repeat (HOLD) @(posedge clk_i);
   endtask : pulse
   task automatic level(input int b, input logic v);
      @(posedge clk_i);
      lvl[b] <= v;
      repeat (HOLD) @(posedge clk_i);
   endtask : level
endmodule : ttc_pin_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`include "ttc_consts.svh"
module tb_top;
   import ttc_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic half_cycle_mode_i = 1;
   logic [3:0] adr_i = 4'h0, sel_i = 4'h1;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic ack_o, clk_out, tx_t, rx_t, t0_q, t1_q, t2_q, e0_q, e1_q;
   ttc_pins_t pins_i;
   int n_mismatch = 0, n_tests = 0, n_cyc = 0;
   always #25 clk_i = ~clk_i;
   ttc_pin_model pins (.clk_i(clk_i), .pins_o(pins_i));
   ttc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .pins_i(pins_i),
      .half_cycle_mode_i(half_cycle_mode_i), .clock_out_pin_o(clk_out),
      .tx_baud_tick_o(tx_t), .rx_baud_tick_o(rx_t), .timer0_irq_o(t0_q),
      .timer1_irq_o(t1_q), .timer2_irq_o(t2_q), .ext0_irq_o(e0_q),
      .ext1_irq_o(e1_q));
   task automatic give_verdict;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   always @(posedge clk_i) begin
      n_cyc++;
      if (n_cyc > 30000) begin
         n_mismatch++;
         give_verdict;
      end
   end
   task automatic check(string n, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic bus(logic [3:0] a, logic w, logic [7:0] d,
      output logic [7:0] q);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask : bus
   task automatic wr(logic [3:0] a, logic [7:0] d);
      logic [7:0] q;
      bus(a, 1'b1, d, q);
   endtask : wr
   task automatic rd(string n, logic [3:0] a, logic [7:0] e);
      logic [7:0] q;
      bus(a, 1'b0, 8'h00, q);
      check(n, e, q);
   endtask : rd
   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask : settle
   task automatic gap(string n, int s, int e);
      int k, t;
      logic p, c;
      t = -1;
      p = 1'b1;
      for (k = 0; k < 600; k++) begin
         @(posedge clk_i);
         #1;
         c = (s == 0) ? tx_t : (s == 1) ? rx_t : clk_out;
         if (c && !p) begin
            if (t >= 0) break;
            t = k;
         end
         p = c;
      end
      check(n, e, k - t);
   endtask : gap
   task automatic test_reset;
      for (int a = 0; a < 16; a++) rd("reset", a[3:0], 8'h00);
      $display("reset test done");
   endtask : test_reset
   task automatic test_rate;
      wr(`TTC_ADR_MODE, 8'h20);
      wr(`TTC_ADR_TH1, 8'hFB);
      wr(`TTC_ADR_TL1, 8'hFB);
      wr(`TTC_ADR_CTRL, 8'h40);
      gap("tx_gap12", 0, 60);
      gap("rx_gap12", 1, 60);
      half_cycle_mode_i <= 1'b0;
      gap("tx_gap6", 0, 30);
      rd("th1_kept", `TTC_ADR_TH1, 8'hFB);
      check("tf1_set", 1'b1, t1_q);
      half_cycle_mode_i <= 1'b1;
      wr(`TTC_ADR_CTRL, 8'h00);
      wr(`TTC_ADR_ACK, 8'h02);
      settle;
      check("tf1_clr", 1'b0, t1_q);
      $display("rate test done");
   endtask : test_rate
   task automatic test_baud;
      wr(`TTC_ADR_CAPL, 8'hFB);
      wr(`TTC_ADR_CAPH, 8'hFF);
      wr(`TTC_ADR_TH2, 8'hFF);
      wr(`TTC_ADR_TL2, 8'hFB);
      wr(`TTC_ADR_TIMER2_RUN_AND_FLAGS, 8'h14);
      gap("t2_tx_gap", 0, 60);
      rd("t2_no_ovf", `TTC_ADR_TIMER2_RUN_AND_FLAGS, 8'h14);
      wr(`TTC_ADR_TIMER2_RUN_AND_FLAGS, 8'h00);
      $display("baud test done");
   endtask : test_baud
   task automatic test_count;
      wr(`TTC_ADR_MODE, 8'h05);
      wr(`TTC_ADR_CTRL, 8'h10);
      pins.pulse(5, 3);
      rd("t0_events", `TTC_ADR_TL0, 8'h03);
      wr(`TTC_ADR_CTRL, 8'h00);
      wr(`TTC_ADR_TL2, 8'h00);
      wr(`TTC_ADR_TH2, 8'h00);
      wr(`TTC_ADR_TIMER2_RUN_AND_FLAGS, 8'h06);
      pins.pulse(3, 2);
      rd("t2_events", `TTC_ADR_TL2, 8'h02);
      $display("counter test done");
   endtask : test_count
   task automatic test_gate;
      wr(`TTC_ADR_MODE, 8'h90);
      wr(`TTC_ADR_TL1, 8'h00);
      pins.level(1, 1'b0);
      wr(`TTC_ADR_CTRL, 8'h40);
      repeat (100) @(posedge clk_i);
      rd("gated", `TTC_ADR_TL1, 8'h00);
      pins.level(1, 1'b1);
      $display("gate test done");
   endtask : test_gate
   task automatic test_ovf;
      wr(`TTC_ADR_MODE, 8'h00);
      wr(`TTC_ADR_TH0, 8'hFF);
      wr(`TTC_ADR_TL0, 8'h1F);
      wr(`TTC_ADR_CTRL, 8'h10);
      for (int k = 0; k < 60 && t0_q !== 1'b1; k++) @(posedge clk_i);
      wr(`TTC_ADR_CTRL, 8'h20);
      rd("th0_wrap", `TTC_ADR_TH0, 8'h00);
      check("tf0_set", 1'b1, t0_q);
      wr(`TTC_ADR_ACK, 8'h01);
      settle;
      check("tf0_ack", 1'b0, t0_q);
      $display("overflow test done");
   endtask : test_ovf
   task automatic test_ext;
      wr(`TTC_ADR_CTRL, 8'h01);
      pins.pulse(2, 1);
      check("ext0_edge", 1'b1, e0_q);
      wr(`TTC_ADR_ACK, 8'h04);
      settle;
      check("ext0_ack", 1'b0, e0_q);
      wr(`TTC_ADR_CTRL, 8'h00);
      pins.level(1, 1'b0);
      check("ext1_lvl", 1'b1, e1_q);
      pins.level(1, 1'b1);
      $display("ext test done");
   endtask : test_ext
   task automatic test_cap;
      wr(`TTC_ADR_TIMER2_RUN_AND_FLAGS, 8'h0D);
      pins.pulse(0, 1);
      rd("timer2_ext_flag_set", `TTC_ADR_TIMER2_RUN_AND_FLAGS, 8'h4D);
      check("t2_irq", 1'b1, t2_q);
      wr(`TTC_ADR_TIMER2_RUN_AND_FLAGS, 8'h05);
      pins.pulse(0, 1);
      rd("exen_off", `TTC_ADR_TIMER2_RUN_AND_FLAGS, 8'h05);
      $display("capture test done");
   endtask : test_cap
   task automatic test_clkout;
      wr(`TTC_ADR_CAPL, 8'hFE);
      wr(`TTC_ADR_CAPH, 8'hFF);
      wr(`TTC_ADR_TH2, 8'hFF);
      wr(`TTC_ADR_TL2, 8'hFE);
      wr(`TTC_ADR_TIMER2_OUTPUT_DIRECTION, 8'h02);
      wr(`TTC_ADR_TIMER2_RUN_AND_FLAGS, 8'h04);
      gap("clk_out", 2, 48);
      check("t2_quiet", 1'b0, t2_q);
      $display("clock out test done");
   endtask : test_clkout
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      test_reset;
      test_rate;
      test_baud;
      test_count;
      test_gate;
      test_ovf;
      test_ext;
      test_cap;
      test_clkout;
      give_verdict;
   end
endmodule : tb_top
